// >>> design/liu_cfg_pkg.sv
// Purpose: shared constants for the per-channel line interface config bank
// Assumes: 8-bit registers, 6-bit register address, two channels
// Notes:   channel 2 copies of per-channel registers sit 0x20 above channel 1
package liu_cfg_pkg;

	// ****************************************************************
	// widths and address map
	// ****************************************************************
	localparam int ADDR_W = 6;                    // register address width
	localparam int DATA_W = 8;                    // register data width
	localparam int NUM_CHAN = 2;                  // line channels
	localparam logic [5:0] CHAN_STRIDE = 6'h20;   // spacing between channels

	localparam logic [5:0] OFF_DEVICE_ID = 6'h00;  // revision, read only
	localparam logic [5:0] OFF_SOFT_RESET = 6'h01; // any write resets bank
	localparam logic [5:0] OFF_GLOBAL_CFG = 6'h20; // mode and broadcast
	localparam logic [5:0] OFF_IRQ_CHAN = 6'h21;   // interrupt_channel_flag
	localparam logic [4:0] OFF_TERM = 5'h02;       // termination_config
	localparam logic [4:0] OFF_ATN = 5'h03;        // jitter_atten_config
	localparam logic [4:0] OFF_TXC0 = 5'h04;       // transmit_config_0
	localparam logic [4:0] OFF_TXC1 = 5'h05;       // transmit_config_1

	// ****************************************************************
	// reset values and writable-bit masks (reserved bits masked off)
	// ****************************************************************
	localparam logic [7:0] RST_TERM = 8'h00;
	localparam logic [7:0] RST_ATN = 8'h20;       // limit mode set at reset
	localparam logic [7:0] RST_TXC0 = 8'h00;
	localparam logic [7:0] RST_TXC1 = 8'h10;      // driver high-z at reset
	localparam logic [7:0] RST_GCF = 8'h04;       // global irq disable set
	localparam logic [7:0] MSK_TERM = 8'h3F;
	localparam logic [7:0] MSK_ATN = 8'h3F;
	localparam logic [7:0] MSK_TXC0 = 8'h1F;
	localparam logic [7:0] MSK_TXC1 = 8'h3F;
	localparam logic [7:0] MSK_GCF = 8'hDF;
	localparam logic [1:0] MSK_IRQ_CHAN = 2'h3;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int TX_TERM_LSB = 3;               // termination 5-3
	localparam int RX_TERM_LSB = 0;               // termination 2-0
	localparam int LIMIT_BIT = 5;                 // atten_limit_mode
	localparam int PLACE_LSB = 3;                 // atten_placement 4-3
	localparam int DEPTH_LSB = 1;                 // atten_depth 2-1
	localparam int BW_BIT = 0;                    // atten_bandwidth
	localparam int TX_OFF_BIT = 4;                // transmitter power down
	localparam int INVERT_BIT = 3;                // tx_data_invert
	localparam int EDGE_BIT = 2;                  // tx_sample_edge
	localparam int MODE_LSB = 0;                  // tx_path_mode 1-0
	localparam int HIZ_BIT = 4;                   // driver high-z, tx byte 1
	localparam int STD_BIT = 4;                   // line_standard_sel
	localparam int COPY_BIT = 3;                  // broadcast enable

	// ****************************************************************
	// decoded values
	// ****************************************************************
	localparam logic [6:0] OHM_75 = 7'h4B;
	localparam logic [6:0] OHM_120 = 7'h78;
	localparam logic [6:0] OHM_100 = 7'h64;
	localparam logic [6:0] OHM_110 = 7'h6E;
	localparam logic [7:0] DEPTH_128 = 8'h80;
	localparam logic [7:0] DEPTH_64 = 8'h40;
	localparam logic [7:0] DEPTH_32 = 8'h20;
	// attenuator corner in hundredths of a hertz
	localparam logic [9:0] CORNER_E1_WIDE = 10'h2A8;  // 6.80 Hz
	localparam logic [9:0] CORNER_T1_WIDE = 10'h1F4;  // 5.00 Hz
	localparam logic [9:0] CORNER_E1_NARROW = 10'h05A; // 0.90 Hz
	localparam logic [9:0] CORNER_T1_NARROW = 10'h07D; // 1.25 Hz

	typedef enum logic [1:0] {
		MODE_LINE_CODE,   // hdb3 or b8zs encoder, single rail
		MODE_AMI,         // ami encoder, single rail
		MODE_BYPASS_0,    // encoder bypassed, dual rail
		MODE_BYPASS_1     // encoder bypassed, dual rail
	} tx_mode_type;

endpackage : liu_cfg_pkg

// >>> design/chan_cfg_decode.sv
// Purpose: turn one channel's raw config bytes into datapath controls
// Assumes: bytes come from flops of the same clock domain
// Notes:   every output is registered, so it lags a write by one cycle
`timescale 1ns/1ns
module chan_cfg_decode (
	input  wire logic       clk_in,          // control clock
	input  wire logic       rst_n_in,        // async reset, active low
	input  wire logic [7:0] term_in,         // termination byte
	input  wire logic [7:0] atn_in,          // attenuator byte
	input  wire logic [7:0] txc0_in,         // transmit byte 0
	input  wire logic [7:0] txc1_in,         // transmit byte 1
	input  wire logic       t1_mode_in,      // 1: t1/j1, 0: e1
	output logic      [6:0] tx_ohms_out,     // tx internal match in ohms
	output logic            tx_ext_out,      // tx external resistors
	output logic      [6:0] rx_ohms_out,     // rx internal match in ohms
	output logic            rx_ext_out,      // rx external resistors
	output logic            atten_tx_out,    // attenuator in tx path
	output logic            atten_rx_out,    // attenuator in rx path
	output logic            atten_limit_out, // attenuator limit mode
	output logic      [7:0] atten_bits_out,  // elastic buffer depth
	output logic      [9:0] atten_corner_out,// corner, 0.01 Hz units
	output logic            tx_power_out,    // transmitter powered
	output logic            tx_hiz_out,      // line driver high-z
	output logic            tx_invert_out,   // input data active low
	output logic            tx_rising_out,   // dual rail sampled rising
	output logic            enc_hdb3_out,    // hdb3 encoder on
	output logic            enc_b8zs_out,    // b8zs encoder on
	output logic            enc_ami_out,     // ami encoder on
	output logic            tx_dual_out      // encoder bypass, dual rail
);

	// ****************************************************************
	// impedance lookup shared by both directions
	// ****************************************************************
	function automatic logic [6:0] ohms(input logic [1:0] code);
		case (code)
			2'h0: ohms = liu_cfg_pkg::OHM_75;
			2'h1: ohms = liu_cfg_pkg::OHM_120;
			2'h2: ohms = liu_cfg_pkg::OHM_100;
			default: ohms = liu_cfg_pkg::OHM_110;
		endcase
	endfunction : ohms

	logic [2:0] tx_term;        // tx termination field
	logic [2:0] rx_term;        // rx termination field
	logic [1:0] place;          // attenuator placement
	logic [1:0] depth;          // attenuator depth code
	liu_cfg_pkg::tx_mode_type mode; // transmit path mode

	assign tx_term = term_in[liu_cfg_pkg::TX_TERM_LSB +: 3];
	assign rx_term = term_in[liu_cfg_pkg::RX_TERM_LSB +: 3];
	assign place = atn_in[liu_cfg_pkg::PLACE_LSB +: 2];
	assign depth = atn_in[liu_cfg_pkg::DEPTH_LSB +: 2];
	assign mode =
		liu_cfg_pkg::tx_mode_type'(txc0_in[liu_cfg_pkg::MODE_LSB +: 2]);

	// ****************************************************************
	// termination decode
	// ****************************************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_ohms_out <= liu_cfg_pkg::OHM_75;
			tx_ext_out <= 1'b0;
			rx_ohms_out <= liu_cfg_pkg::OHM_75;
			rx_ext_out <= 1'b0;
		end else begin
			tx_ohms_out <= ohms(tx_term[1:0]);
			tx_ext_out <= tx_term[2] & ~t1_mode_in;
			rx_ohms_out <= ohms(rx_term[1:0]);
			rx_ext_out <= rx_term[2];
		end
	end

	// ****************************************************************
	// jitter attenuator decode
	// ****************************************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			atten_tx_out <= 1'b0;
			atten_rx_out <= 1'b0;
			atten_limit_out <= 1'b1;
			atten_bits_out <= liu_cfg_pkg::DEPTH_128;
			atten_corner_out <= liu_cfg_pkg::CORNER_E1_WIDE;
		end else begin
			atten_limit_out <= atn_in[liu_cfg_pkg::LIMIT_BIT];
			atten_tx_out <= (place == 2'h1);
			atten_rx_out <= (place == 2'h3);
			// upper depth bit alone forces the shallowest buffer
			if (depth[1]) begin
				atten_bits_out <= liu_cfg_pkg::DEPTH_32;
			end else if (depth[0]) begin
				atten_bits_out <= liu_cfg_pkg::DEPTH_64;
			end else begin
				atten_bits_out <= liu_cfg_pkg::DEPTH_128;
			end
			case ({atn_in[liu_cfg_pkg::BW_BIT], t1_mode_in})
				2'h0: atten_corner_out <= liu_cfg_pkg::CORNER_E1_WIDE;
				2'h1: atten_corner_out <= liu_cfg_pkg::CORNER_T1_WIDE;
				2'h2: atten_corner_out <= liu_cfg_pkg::CORNER_E1_NARROW;
				default: atten_corner_out <= liu_cfg_pkg::CORNER_T1_NARROW;
			endcase
		end
	end

	// ****************************************************************
	// transmit path decode
	// ****************************************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_power_out <= 1'b1;
			tx_hiz_out <= 1'b1;
			tx_invert_out <= 1'b0;
			tx_rising_out <= 1'b0;
			enc_hdb3_out <= 1'b1;
			enc_b8zs_out <= 1'b0;
			enc_ami_out <= 1'b0;
			tx_dual_out <= 1'b0;
		end else begin
			tx_power_out <= ~txc0_in[liu_cfg_pkg::TX_OFF_BIT];
			// power down also floats the driver
			tx_hiz_out <= txc0_in[liu_cfg_pkg::TX_OFF_BIT] |
				txc1_in[liu_cfg_pkg::HIZ_BIT];
			tx_invert_out <= txc0_in[liu_cfg_pkg::INVERT_BIT];
			tx_rising_out <= txc0_in[liu_cfg_pkg::EDGE_BIT];
			enc_hdb3_out <= 1'b0;
			enc_b8zs_out <= 1'b0;
			enc_ami_out <= 1'b0;
			tx_dual_out <= 1'b0;
			case (mode)
				liu_cfg_pkg::MODE_LINE_CODE: begin
					enc_hdb3_out <= ~t1_mode_in;
					enc_b8zs_out <= t1_mode_in;
				end
				liu_cfg_pkg::MODE_AMI: begin
					enc_ami_out <= 1'b1;
				end
				default: begin
					tx_dual_out <= 1'b1;
				end
			endcase
		end
	end

endmodule : chan_cfg_decode

// >>> design/liu_channel_config_regs.sv
// Purpose: per-channel config register bank of a dual line interface
// Assumes: host port is synchronous to CORE_CLK_IN; one access per cycle
// Notes:   read data is registered and appears the cycle after the strobe
//
// How it works
// - irq flag bit low means channel interrupted
// - each channel register repeats 0x20 higher
// - tx termination 75/120/100/110 or external E1
// - rx termination 75/120/100/110 or external
// - limit bit selects limit mode, resets one
// - placement 01 tx, 11 rx, else off
// - depth 128, 64, or 32 bits
// - bandwidth bit picks wide or narrow corner
// - power-down bit stops transmitter, floats driver
// - invert bit makes transmit data active low
// - edge bit picks rising or falling sampling
// - mode 00 uses hdb3/b8zs, single rail
// - mode 01 uses ami, single rail
// - mode 1x bypasses encoder, dual rail
// - global mode bit selects E1 or T1/J1
// - broadcast bit copies writes to both channels
// - any soft-reset write restores all defaults
`timescale 1ns/1ns
module liu_channel_config_regs #(
	parameter logic [7:0] DEVICE_ID = 8'h00 // arbitrary revision value
) (
	input  wire logic            CORE_CLK_IN,          // control clock
	input  wire logic            RST_N_IN,             // async reset, low
	input  wire logic      [5:0] REG_ADDR_IN,          // register address
	input  wire logic      [7:0] REG_WDATA_IN,         // write data
	input  wire logic            REG_WR_IN,            // write strobe
	input  wire logic            REG_RD_IN,            // read strobe
	input  wire logic      [1:0] CHAN_IRQ_IN,          // per-channel irq
	output logic           [7:0] REG_RDATA_OUT,        // read data
	output logic                 LINE_STANDARD_SEL_OUT,// 1: t1/j1
	output logic           [1:0] MONITOR_SEL_OUT,      // monitor control
	output logic                 IRQ_GLOBAL_OFF_OUT,   // irqs all masked
	output logic           [1:0] IRQ_PIN_MODE_OUT,     // irq pin style
	output logic      [1:0][6:0] TX_TERM_OHMS_OUT,     // tx match, ohms
	output logic           [1:0] TX_TERM_EXT_OUT,      // tx external
	output logic      [1:0][6:0] RX_TERM_OHMS_OUT,     // rx match, ohms
	output logic           [1:0] RX_TERM_EXT_OUT,      // rx external
	output logic           [1:0] ATTEN_IN_TX_OUT,      // atten in tx path
	output logic           [1:0] ATTEN_IN_RX_OUT,      // atten in rx path
	output logic           [1:0] ATTEN_LIMIT_MODE_OUT, // limit mode
	output logic      [1:0][7:0] ATTEN_DEPTH_OUT,      // depth in bits
	output logic      [1:0][9:0] ATTEN_BANDWIDTH_OUT,  // corner 0.01 Hz
	output logic           [1:0] TX_POWERED_OUT,       // tx powered up
	output logic           [1:0] TX_DRIVER_HIZ_OUT,    // driver high-z
	output logic           [1:0] TX_DATA_INVERT_OUT,   // data active low
	output logic           [1:0] TX_SAMPLE_EDGE_OUT,   // 1: rising edge
	output logic           [1:0] TX_ENC_HDB3_OUT,      // hdb3 encoder
	output logic           [1:0] TX_ENC_B8ZS_OUT,      // b8zs encoder
	output logic           [1:0] TX_ENC_AMI_OUT,       // ami encoder
	output logic           [1:0] TX_DUAL_RAIL_OUT,     // encoder bypass
	output logic           [1:0][1:0] TX_PATH_MODE_OUT // raw mode code
);

	// ****************************************************************
	// storage
	// ****************************************************************
	logic [7:0] gcf_q;                  // global configuration
	logic [1:0][7:0] term_q;            // termination per channel
	logic [1:0][7:0] atn_q;             // attenuator per channel
	logic [1:0][7:0] txc0_q;            // transmit 0 per channel
	logic [1:0][7:0] txc1_q;            // transmit 1 per channel
	logic [7:0] rdata_d;                // read mux result
	logic soft_rst;                     // soft reset write seen
	logic broadcast;                    // mirror writes to both channels
	logic [4:0] low_addr;               // address within channel window
	logic chan_sel;                     // addressed channel, 0 is ch1

	assign low_addr = REG_ADDR_IN[4:0];
	assign chan_sel = REG_ADDR_IN[5];
	assign broadcast = gcf_q[liu_cfg_pkg::COPY_BIT];
	// any value written here resets; the register itself holds nothing
	assign soft_rst = REG_WR_IN &&
		(REG_ADDR_IN == liu_cfg_pkg::OFF_SOFT_RESET);

	// ****************************************************************
	// global configuration register
	// ****************************************************************
	// soft reset takes effect at the edge that samples the write
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			gcf_q <= liu_cfg_pkg::RST_GCF;
		end else if (soft_rst) begin
			gcf_q <= liu_cfg_pkg::RST_GCF;
		end else if (REG_WR_IN &&
			(REG_ADDR_IN == liu_cfg_pkg::OFF_GLOBAL_CFG)) begin
			gcf_q <= REG_WDATA_IN & liu_cfg_pkg::MSK_GCF;
		end
	end

	assign LINE_STANDARD_SEL_OUT = gcf_q[liu_cfg_pkg::STD_BIT];
	assign MONITOR_SEL_OUT = gcf_q[7:6];
	assign IRQ_GLOBAL_OFF_OUT = gcf_q[2];
	assign IRQ_PIN_MODE_OUT = gcf_q[1:0];

	// ****************************************************************
	// per-channel registers and decoders
	// ****************************************************************
	for (genvar ch = 0; ch < liu_cfg_pkg::NUM_CHAN; ch++) begin : g_chan
		logic hit;                      // write reaches this channel

		// broadcast lets a write to either copy land in both
		assign hit = REG_WR_IN &&
			((chan_sel == 1'(ch)) || broadcast);

		// channel register writes, reserved bits dropped
		always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
			if (!RST_N_IN) begin
				term_q[ch] <= liu_cfg_pkg::RST_TERM;
				atn_q[ch] <= liu_cfg_pkg::RST_ATN;
				txc0_q[ch] <= liu_cfg_pkg::RST_TXC0;
				txc1_q[ch] <= liu_cfg_pkg::RST_TXC1;
			end else if (soft_rst) begin
				term_q[ch] <= liu_cfg_pkg::RST_TERM;
				atn_q[ch] <= liu_cfg_pkg::RST_ATN;
				txc0_q[ch] <= liu_cfg_pkg::RST_TXC0;
				txc1_q[ch] <= liu_cfg_pkg::RST_TXC1;
			end else if (hit) begin
				case (low_addr)
					liu_cfg_pkg::OFF_TERM: begin
						term_q[ch] <= REG_WDATA_IN &
							liu_cfg_pkg::MSK_TERM;
					end
					liu_cfg_pkg::OFF_ATN: begin
						atn_q[ch] <= REG_WDATA_IN &
							liu_cfg_pkg::MSK_ATN;
					end
					liu_cfg_pkg::OFF_TXC0: begin
						txc0_q[ch] <= REG_WDATA_IN &
							liu_cfg_pkg::MSK_TXC0;
					end
					liu_cfg_pkg::OFF_TXC1: begin
						txc1_q[ch] <= REG_WDATA_IN &
							liu_cfg_pkg::MSK_TXC1;
					end
					default: begin
						// other offsets belong to other banks
					end
				endcase
			end
		end

		assign TX_PATH_MODE_OUT[ch] = txc0_q[ch][liu_cfg_pkg::MODE_LSB +: 2];

		// decoded controls that steer this channel's datapaths
		chan_cfg_decode u_decode (
			.clk_in           (CORE_CLK_IN),
			.rst_n_in         (RST_N_IN),
			.term_in          (term_q[ch]),
			.atn_in           (atn_q[ch]),
			.txc0_in          (txc0_q[ch]),
			.txc1_in          (txc1_q[ch]),
			.t1_mode_in       (gcf_q[liu_cfg_pkg::STD_BIT]),
			.tx_ohms_out      (TX_TERM_OHMS_OUT[ch]),
			.tx_ext_out       (TX_TERM_EXT_OUT[ch]),
			.rx_ohms_out      (RX_TERM_OHMS_OUT[ch]),
			.rx_ext_out       (RX_TERM_EXT_OUT[ch]),
			.atten_tx_out     (ATTEN_IN_TX_OUT[ch]),
			.atten_rx_out     (ATTEN_IN_RX_OUT[ch]),
			.atten_limit_out  (ATTEN_LIMIT_MODE_OUT[ch]),
			.atten_bits_out   (ATTEN_DEPTH_OUT[ch]),
			.atten_corner_out (ATTEN_BANDWIDTH_OUT[ch]),
			.tx_power_out     (TX_POWERED_OUT[ch]),
			.tx_hiz_out       (TX_DRIVER_HIZ_OUT[ch]),
			.tx_invert_out    (TX_DATA_INVERT_OUT[ch]),
			.tx_rising_out    (TX_SAMPLE_EDGE_OUT[ch]),
			.enc_hdb3_out     (TX_ENC_HDB3_OUT[ch]),
			.enc_b8zs_out     (TX_ENC_B8ZS_OUT[ch]),
			.enc_ami_out      (TX_ENC_AMI_OUT[ch]),
			.tx_dual_out      (TX_DUAL_RAIL_OUT[ch])
		);
	end

	// ****************************************************************
	// read path
	// ****************************************************************
	// select the addressed register; unmapped addresses read zero
	always_comb begin
		rdata_d = 8'h00;
		case (REG_ADDR_IN)
			liu_cfg_pkg::OFF_DEVICE_ID: begin
				rdata_d = DEVICE_ID;
			end
			liu_cfg_pkg::OFF_GLOBAL_CFG: begin
				rdata_d = gcf_q;
			end
			liu_cfg_pkg::OFF_IRQ_CHAN: begin
				// a channel with an interrupt pending reads as zero
				rdata_d = {6'h00,
					~CHAN_IRQ_IN & liu_cfg_pkg::MSK_IRQ_CHAN};
			end
			default: begin
				case (low_addr)
					liu_cfg_pkg::OFF_TERM: begin
						rdata_d = term_q[chan_sel];
					end
					liu_cfg_pkg::OFF_ATN: begin
						rdata_d = atn_q[chan_sel];
					end
					liu_cfg_pkg::OFF_TXC0: begin
						rdata_d = txc0_q[chan_sel];
					end
					liu_cfg_pkg::OFF_TXC1: begin
						rdata_d = txc1_q[chan_sel];
					end
					default: begin
						rdata_d = 8'h00;
					end
				endcase
			end
		endcase
	end

	// read data captured on the strobe and held until the next read
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			REG_RDATA_OUT <= 8'h00;
		end else if (REG_RD_IN) begin
			REG_RDATA_OUT <= rdata_d;
		end
	end

endmodule : liu_channel_config_regs

// >>> sim/liu_cfg_chk_sva.sv
// Purpose: port assertions for the channel config register bank
// Assumes: one clock, reset asynchronous and active low
// Notes:   decoded outputs lag their register by one clock
`timescale 1ns/1ns
module liu_cfg_chk (
	input wire logic            CORE_CLK_IN,          // clock
	input wire logic            RST_N_IN,             // reset, low
	input wire logic      [5:0] REG_ADDR_IN,          // address
	input wire logic      [7:0] REG_WDATA_IN,         // write data
	input wire logic            REG_WR_IN,            // write strobe
	input wire logic            REG_RD_IN,            // read strobe
	input wire logic      [1:0] CHAN_IRQ_IN,          // channel irqs
	input wire logic      [7:0] REG_RDATA_OUT,        // read data
	input wire logic            LINE_STANDARD_SEL_OUT,// 1: t1/j1
	input wire logic      [1:0] TX_POWERED_OUT,       // tx powered
	input wire logic      [1:0] TX_DRIVER_HIZ_OUT,    // driver high-z
	input wire logic      [1:0] TX_ENC_HDB3_OUT,      // hdb3 on
	input wire logic      [1:0] TX_ENC_AMI_OUT,       // ami on
	input wire logic      [1:0] TX_DUAL_RAIL_OUT,     // dual rail
	input wire logic [1:0][1:0] TX_PATH_MODE_OUT      // raw mode
);
	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	// read data tracks the channel irq inputs, inverted
	chk_irq_flag_read: assert property (
		REG_RD_IN && REG_ADDR_IN == 6'h21
		|=> REG_RDATA_OUT == {6'h00, ~$past(CHAN_IRQ_IN)})
		else $error("irq channel flag read wrong");
	chk_enc_line_code: assert property (
		TX_ENC_HDB3_OUT[0] == ($past(TX_PATH_MODE_OUT[0]) == 2'h0
		&& !$past(LINE_STANDARD_SEL_OUT)))
		else $error("line code encoder select wrong");
	chk_enc_ami: assert property (
		TX_ENC_AMI_OUT[0] == ($past(TX_PATH_MODE_OUT[0]) == 2'h1))
		else $error("ami encoder select wrong");
	chk_dual_rail: assert property (
		TX_DUAL_RAIL_OUT[1] == $past(TX_PATH_MODE_OUT[1][1]))
		else $error("dual rail select wrong");
	chk_soft_reset_all: assert property (
		REG_WR_IN && REG_ADDR_IN == 6'h01
		|=> TX_PATH_MODE_OUT == 4'h0 && !LINE_STANDARD_SEL_OUT
		##1 TX_DRIVER_HIZ_OUT == 2'h3 && TX_POWERED_OUT == 2'h3)
		else $error("soft reset left a register set");
	chk_chan_two_mode: assert property (
		REG_WR_IN && REG_ADDR_IN == 6'h24
		|=> TX_PATH_MODE_OUT[1] == $past(REG_WDATA_IN[1:0]))
		else $error("channel two mode not written");
	chk_power_down_hiz: assert property (
		REG_WR_IN && REG_ADDR_IN == 6'h04 |-> ##2
		TX_POWERED_OUT[0] != $past(REG_WDATA_IN[4], 2)
		&& (TX_POWERED_OUT[0] || TX_DRIVER_HIZ_OUT[0]))
		else $error("power down or high-z wrong");
	chk_standard_write: assert property (
		REG_WR_IN && REG_ADDR_IN == 6'h20
		|=> LINE_STANDARD_SEL_OUT == $past(REG_WDATA_IN[4]))
		else $error("line standard not written");
	cov_soft_reset: cover property (REG_WR_IN && REG_ADDR_IN == 6'h01);
	cov_irq_read: cover property (REG_RD_IN && REG_ADDR_IN == 6'h21);
	cov_dual_both: cover property (TX_DUAL_RAIL_OUT == 2'h3);
endmodule : liu_cfg_chk
bind liu_channel_config_regs liu_cfg_chk chk (.*);

// >>> sim/host_model.sv
// Purpose: host processor on the register port
// Assumes: strobes change 1 ns after a rising edge
// Notes:   one access every other cycle, strobe high for one edge
`timescale 1ns/1ns
module host_model (
	input  wire logic       clk_in,    // control clock
	input  wire logic [7:0] rdata_in,  // read data
	output logic      [5:0] addr_out,  // address
	output logic      [7:0] wdata_out, // write data
	output logic            wr_out,    // write strobe
	output logic            rd_out     // read strobe
);
	// idle port at time zero
	initial begin
		{addr_out, wdata_out, wr_out, rd_out} = '0;
	end
	// one access: strobe held to the taking edge, data read after it
	task automatic access(input logic w, input logic [5:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_in) #1;
		{addr_out, wdata_out, wr_out, rd_out} = {a, d, w, ~w};
		@(posedge clk_in) #1;
		q = rdata_in;
		{wr_out, rd_out} = 2'h0;
	endtask : access
endmodule : host_model

// >>> sim/tb_top.sv
// Purpose: self-checking bench for the channel config register bank
// Assumes: host_model drives the port, m mirrors the registers
// Notes:   decoded outputs are compared one clock after each write
`timescale 1ns/1ns
module tb_top;
	logic CORE_CLK_IN = 1'b0;
	logic RST_N_IN = 1'b0;
	logic [1:0] CHAN_IRQ_IN = 2'h0;
	logic [5:0] REG_ADDR_IN;
	logic [7:0] REG_WDATA_IN, REG_RDATA_OUT;
	logic REG_WR_IN, REG_RD_IN, LINE_STANDARD_SEL_OUT, IRQ_GLOBAL_OFF_OUT;
	logic [1:0] MONITOR_SEL_OUT, IRQ_PIN_MODE_OUT, TX_TERM_EXT_OUT,
		RX_TERM_EXT_OUT, ATTEN_IN_TX_OUT, ATTEN_IN_RX_OUT,
		ATTEN_LIMIT_MODE_OUT, TX_POWERED_OUT, TX_DRIVER_HIZ_OUT,
		TX_DATA_INVERT_OUT, TX_SAMPLE_EDGE_OUT, TX_ENC_HDB3_OUT,
		TX_ENC_B8ZS_OUT, TX_ENC_AMI_OUT, TX_DUAL_RAIL_OUT;
	logic [1:0][6:0] TX_TERM_OHMS_OUT, RX_TERM_OHMS_OUT;
	logic [1:0][7:0] ATTEN_DEPTH_OUT;
	logic [1:0][9:0] ATTEN_BANDWIDTH_OUT;
	logic [1:0][1:0] TX_PATH_MODE_OUT;
	logic [7:0] m [64]; // register image of the bench model
	int num_errors = 0;
	int total_checks = 0;
	// free-running 125 MHz control clock
	always #4 CORE_CLK_IN = ~CORE_CLK_IN;
	liu_channel_config_regs dut (.*);
	host_model host (.clk_in(CORE_CLK_IN), .rdata_in(REG_RDATA_OUT),
		.addr_out(REG_ADDR_IN), .wdata_out(REG_WDATA_IN),
		.wr_out(REG_WR_IN), .rd_out(REG_RD_IN));
	// one comparison; any difference is counted and reported
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	// counts, verdict and end of the run
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	// model defaults, also restored by a soft reset
	function automatic void defaults();
		m = '{default: 8'h00};
		m[32] = 8'h04;
		m[3] = 8'h20;
		m[35] = 8'h20;
		m[5] = 8'h10;
		m[37] = 8'h10;
	endfunction : defaults
	// writable bits of a per-channel register, zero where unmapped
	function automatic logic [7:0] mask(input logic [5:0] a);
		case (a[4:0])
			5'h02, 5'h03, 5'h05: return 8'h3F;
			5'h04: return 8'h1F;
			default: return 8'h00;
		endcase
	endfunction : mask
	function automatic logic [6:0] ohm(input logic [1:0] k);
		return k[1] ? (k[0] ? 7'h6E : 7'h64) : (k[0] ? 7'h78 : 7'h4B);
	endfunction : ohm
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] q;
		host.access(1'b1, a, d, q);
		if (a == 6'h01)
			defaults();
		else if (a == 6'h20)
			m[32] = d & 8'hDF;
		else if (mask(a) != 8'h00) begin
			m[a] = d & mask(a);
			if (m[32][3])
				m[a ^ 6'h20] = m[a];
		end
	endtask : wr
	task automatic rd(input logic [5:0] a);
		logic [7:0] q;
		host.access(1'b0, a, 8'h00, q);
		check(q, a == 6'h21 ? {6'h00, ~CHAN_IRQ_IN} : m[a]);
	endtask : rd
	// decoded outputs of both channels against the model image
	task automatic dec();
		logic [7:0] t, j, x;
		logic s;
		@(posedge CORE_CLK_IN) #1;
		s = m[32][4];
		check({MONITOR_SEL_OUT, IRQ_GLOBAL_OFF_OUT, IRQ_PIN_MODE_OUT,
			LINE_STANDARD_SEL_OUT}, {m[32][7:6], m[32][2:0], s});
		for (int c = 0; c < 2; c++) begin
			t = m[c * 32 + 2];
			j = m[c * 32 + 3];
			x = m[c * 32 + 4];
			check({TX_TERM_OHMS_OUT[c], TX_TERM_EXT_OUT[c],
				RX_TERM_OHMS_OUT[c], RX_TERM_EXT_OUT[c]},
				{ohm(t[4:3]), t[5] & ~s, ohm(t[1:0]), t[2]});
			check({ATTEN_IN_TX_OUT[c], ATTEN_IN_RX_OUT[c],
				ATTEN_LIMIT_MODE_OUT[c], ATTEN_DEPTH_OUT[c],
				ATTEN_BANDWIDTH_OUT[c]}, {j[4:3] == 2'h1, j[4:3] == 2'h3, j[5],
				j[2] ? 8'h20 : (j[1] ? 8'h40 : 8'h80), j[0] ?
				(s ? 10'h07D : 10'h05A) : (s ? 10'h1F4 : 10'h2A8)});
			check({TX_POWERED_OUT[c], TX_DRIVER_HIZ_OUT[c],
				TX_DATA_INVERT_OUT[c], TX_SAMPLE_EDGE_OUT[c],
				TX_ENC_HDB3_OUT[c], TX_ENC_B8ZS_OUT[c],
				TX_ENC_AMI_OUT[c], TX_DUAL_RAIL_OUT[c], TX_PATH_MODE_OUT[c]},
				{~x[4], x[4] | m[c * 32 + 5][4], x[3], x[2], x[1:0] == 2'h0 && !s,
				x[1:0] == 2'h0 && s, x[1:0] == 2'h1, x[1], x[1:0]});
		end
	endtask : dec
	// main sequence: reset values, random traffic, final sweep
	initial begin
		logic [5:0] a;
		defaults();
		void'($urandom(72));
		repeat (3) @(posedge CORE_CLK_IN);
		#1 RST_N_IN = 1'b1;
		dec();
		for (int i = 0; i < 64; i++)
			rd(6'(i));
		$display("reset value test done");
		for (int i = 0; i < 160; i++) begin
			a = (i % 8 == 7) ? 6'($urandom) : {1'($urandom), 5'(2 + i % 4)};
			if (i % 16 == 5)
				a = 6'h20;
			if (i == 80)
				a = 6'h01;
			CHAN_IRQ_IN = 2'($urandom);
			wr(a, 8'($urandom));
			dec();
			rd(a);
			rd(6'h21);
		end
		$display("random write test done");
		for (int i = 0; i < 64; i++)
			rd(6'(i));
		$display("final sweep test done");
		complete_run();
	end
	// cut a hang short
	initial begin
		#200000;
		num_errors++;
		complete_run();
	end
endmodule : tb_top
